/* File: delay_paced_frame_injector.sv */
// delay-paced frame injector: per-flow sequence walker over a shared frame table
// assumes avalon-mm master on clk_i and an injection sink on the same clock

`timescale 1ns/1ps

module delay_paced_frame_injector #(
	parameter int unsigned FLOWS      = 32,
	parameter int unsigned FTAB_DEPTH = 4096,
	parameter logic [6:0]  LOOPBACK_PORT = 7'h40
) (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [15:0] avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        inject_ready_i,
	output logic             inject_valid_o,
	output logic      [10:0] inject_frame_o,
	output logic      [6:0]  inject_port_o,
	output logic      [10:0] inject_qidx_o,
	output logic      [2:0]  inject_qinp_o,
	output logic             inject_rate_class_o,
	output logic             inject_loopback_o,
	output logic      [4:0]  inject_flow_o
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (FLOWS < 1 || FLOWS > frame_injector_pkg::FLOW_MAX) begin : g_bad_flows
		$error("FLOWS must lie between 1 and 32");
	end
	if (FTAB_DEPTH < 2 || FTAB_DEPTH > frame_injector_pkg::FTAB_MAX) begin : g_bad_depth
		$error("FTAB_DEPTH must lie between 2 and 4096");
	end

	localparam int unsigned PW = frame_injector_pkg::PTR_W;
	localparam int unsigned WW = frame_injector_pkg::WAIT_W;
	// unused destination bits other than bit 19 read back as zero
	localparam logic [31:0] DEST_MASK = 32'h807F_FF7F;
	localparam logic signed [WW-1:0] WAIT_ONE = WW'(1);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] be_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] be);
		logic [31:0] r;
		r = old_w;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// round-robin pick, searching upward from the flow after the last one served
	function automatic logic [4:0] rr_pick(input logic [31:0] req, input logic [4:0] last);
		logic [4:0] r;
		logic [4:0] c;
		r = last;
		for (int k = 32; k >= 1; k--) begin
			c = 5'(int'(last) + k);
			if (req[c]) begin
				r = c;
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [31:0]    ftab_mem [FTAB_DEPTH];           // shared frame/delay entries
	logic           mode_q   [FLOWS];
	logic [7:0]     trail_n_q[FLOWS];
	logic [PW-1:0]  head_q   [FLOWS];
	logic [PW-1:0]  cursor_q [FLOWS];
	logic [15:0]    count_q  [FLOWS];
	logic [31:0]    dest_q   [FLOWS];
	logic           ena_q    [FLOWS];
	logic           rate_q   [FLOWS];
	logic [4:0]     succ_q   [FLOWS];
	logic           chain_q  [FLOWS];
	logic [7:0]     rep_q    [FLOWS];
	logic [PW-1:0]  ret_q    [FLOWS];
	logic           retv_q   [FLOWS];
	logic [7:0]     trail_q  [FLOWS];
	logic signed [WW-1:0] wait_q [FLOWS];

	frame_injector_pkg::engine_state_type eng_state_q;
	logic [4:0]  eng_flow_q;
	logic [3:0]  proc_cnt_q;
	logic [31:0] entry_q;
	logic [PW-1:0] entry_ptr_q;
	logic [31:0] rdata_q;
	logic        wait_req_q;
	logic        inj_valid_q;
	logic [10:0] inj_frame_q;
	logic [6:0]  inj_port_q;
	logic [10:0] inj_qidx_q;
	logic [2:0]  inj_qinp_q;
	logic        inj_rate_q;
	logic        inj_loop_q;
	logic [4:0]  inj_flow_q;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// a request is taken on the edge where it meets waitrequest low
	wire         bus_req    = avs_read_i | avs_write_i;
	wire         bus_take   = bus_req & ~wait_req_q;
	wire         bus_wr     = avs_write_i & ~wait_req_q;
	wire         is_ftab    = avs_address_i[15:14] == frame_injector_pkg::FTAB_BASE[15:14];
	wire [PW-1:0] ftab_idx  = avs_address_i[13:2];
	wire         ftab_hit   = is_ftab && (int'(ftab_idx) < FTAB_DEPTH);
	wire [4:0]   bus_flow   = avs_address_i[9:5];
	wire [4:0]   bus_reg    = {avs_address_i[4:2], 2'b00};
	wire         flow_hit   = (avs_address_i[15:10] == 6'h00) && (int'(bus_flow) < FLOWS);
	wire         wr_mode    = bus_wr && flow_hit && bus_reg == frame_injector_pkg::REG_MODE;
	wire         wr_ptrs    = bus_wr && flow_hit && bus_reg == frame_injector_pkg::REG_PTRS;
	wire         wr_count   = bus_wr && flow_hit && bus_reg == frame_injector_pkg::REG_COUNT;
	wire         wr_dest    = bus_wr && flow_hit && bus_reg == frame_injector_pkg::REG_DEST;
	wire         wr_ctrl    = bus_wr && flow_hit && bus_reg == frame_injector_pkg::REG_CTRL;

	// readback words; engine-owned fields show live flow state
	wire [31:0] rd_mode  = {16'h0000, trail_n_q[bus_flow], 7'h00, mode_q[bus_flow]};
	wire [31:0] rd_ptrs  = {4'h0, cursor_q[bus_flow], 4'h0, head_q[bus_flow]};
	wire [31:0] rd_count = {16'h0000, count_q[bus_flow]};
	wire [31:0] rd_ctrl  = {rep_q[bus_flow], 10'h000, chain_q[bus_flow], succ_q[bus_flow],
		6'h00, rate_q[bus_flow], ena_q[bus_flow]};
	logic [31:0] rd_word;

	always_comb begin
		rd_word = frame_injector_pkg::READ_UNMAPPED;
		if (ftab_hit) begin
			rd_word = ftab_mem[ftab_idx];
		end else if (flow_hit) begin
			case (bus_reg)
				frame_injector_pkg::REG_MODE:  rd_word = rd_mode;
				frame_injector_pkg::REG_PTRS:  rd_word = rd_ptrs;
				frame_injector_pkg::REG_COUNT: rd_word = rd_count;
				frame_injector_pkg::REG_DEST:  rd_word = dest_q[bus_flow];
				frame_injector_pkg::REG_CTRL:  rd_word = rd_ctrl;
				default:                       rd_word = frame_injector_pkg::READ_UNMAPPED;
			endcase
		end
	end

	// one wait cycle per access; waitrequest rises again right after the take
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wait_req_q <= 1'b1;
			rdata_q    <= frame_injector_pkg::RST_WORD;
		end else begin
			wait_req_q <= ~(bus_req & wait_req_q);
			if (bus_req && wait_req_q) begin
				rdata_q <= rd_word;
			end
		end
	end

	// frame table writes; memory needs no reset, software fills it before enabling
	always_ff @(posedge clk_i) begin
		if (bus_wr && ftab_hit) begin
			ftab_mem[ftab_idx] <= be_merge(ftab_mem[ftab_idx], avs_writedata_i, avs_byteenable_i);
		end
	end

	// ----------------------------------------------------------------
	// engine: entry decode and effect of processing it
	// ----------------------------------------------------------------
	wire [4:0]    f          = eng_flow_q;
	wire          ent_delay  = entry_q[frame_injector_pkg::TYPE_BIT];
	wire [PW-1:0] ent_next   = entry_q[frame_injector_pkg::NEXT_LSB +: PW];
	wire [7:0]    ent_rep    = entry_q[frame_injector_pkg::REPEAT_LSB +: 8];
	wire [7:0]    rep_goal   = (ent_rep == 8'h00) ? 8'h01 : ent_rep;
	wire [WW-1:0] ent_cycles = {2'b00, entry_q[frame_injector_pkg::DELAY_W-1:0]};
	wire          at_end     = ent_next == '0;
	wire          pass_end   = at_end || ent_next == head_q[f];
	wire          next_delay = !at_end && ftab_mem[ent_next][frame_injector_pkg::TYPE_BIT];
	wire          more_rep   = !ent_delay && (9'(rep_q[f]) + 9'h001 < 9'(rep_goal));
	wire          finishing  = at_end && mode_q[f] && count_q[f] <= 16'h0001;
	wire [7:0]    trail_inc  = trail_q[f] + 8'h01;
	wire          trail_wrap = trail_inc >= trail_n_q[f];

	wire apply_delay = eng_state_q == frame_injector_pkg::ENG_PROC && proc_cnt_q == '0
		&& ent_delay;
	wire apply_frame = eng_state_q == frame_injector_pkg::ENG_INJECT && inject_ready_i;
	wire apply       = apply_delay | apply_frame;

	logic [PW-1:0] a_cursor;
	logic [7:0]    a_rep;
	logic          a_retv;
	logic [WW-1:0] a_delay;
	logic [15:0]   a_count;
	logic [7:0]    a_trail;
	logic          a_finish;

	// next flow state once the current entry has been processed
	always_comb begin
		a_cursor = at_end ? head_q[f] : ent_next;
		a_rep    = 8'h00;
		a_retv   = 1'b0;
		a_delay  = '0;
		a_count  = count_q[f];
		a_trail  = trail_q[f];
		a_finish = 1'b0;
		if (more_rep) begin
			// go through the following delay if the next entry is one, else repeat at once; then return here
			a_rep    = rep_q[f] + 8'h01;
			a_retv   = 1'b1;
			a_cursor = next_delay ? ent_next : cursor_q[f];
		end else if (ent_delay && retv_q[f]) begin
			a_retv   = 1'b1;
			a_rep    = rep_q[f];
			a_cursor = ret_q[f];
			a_delay  = ent_cycles;
		end else begin
			// a later delay is only reached after all repeats
			if (ent_delay) begin
				a_delay = (pass_end && trail_q[f] != 8'h00) ? '0 : ent_cycles;
			end
			if (pass_end) begin
				a_trail = trail_wrap ? 8'h00 : trail_inc;
			end
			if (at_end) begin
				// count mode counts passes left, repeat mode counts passes done
				a_count = mode_q[f] ? count_q[f] - 16'h0001 : count_q[f] + 16'h0001;
			end
			if (finishing) begin
				a_finish = 1'b1;
				a_delay  = '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// flow table
	// ----------------------------------------------------------------
	logic [31:0] eligible;

	// a flow is served once its pending delay has run out
	always_comb begin
		eligible = 32'h0000_0000;
		for (int i = 0; i < FLOWS; i++) begin
			eligible[i] = ena_q[i] && wait_q[i] <= 0;
		end
	end

	wire chain_go = apply && a_finish && chain_q[f];

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < FLOWS; i++) begin
				mode_q[i]    <= 1'b0;
				trail_n_q[i] <= 8'h00;
				head_q[i]    <= '0;
				cursor_q[i]  <= '0;
				count_q[i]   <= 16'h0000;
				dest_q[i]    <= frame_injector_pkg::RST_WORD;
				ena_q[i]     <= 1'b0;
				rate_q[i]    <= 1'b0;
				succ_q[i]    <= 5'h00;
				chain_q[i]   <= 1'b0;
				rep_q[i]     <= 8'h00;
				ret_q[i]     <= '0;
				retv_q[i]    <= 1'b0;
				trail_q[i]   <= 8'h00;
				wait_q[i]    <= '0;
			end
		end else begin
			for (int i = 0; i < FLOWS; i++) begin
				// each flow's delay counts down on its own; the floor caps
				// how much overshoot can be paid back later
				if (wait_q[i] > frame_injector_pkg::WAIT_FLOOR) begin
					wait_q[i] <= wait_q[i] - WAIT_ONE;
				end
				if (apply && 5'(i) == f) begin
					cursor_q[i] <= a_cursor;
					rep_q[i]    <= a_rep;
					retv_q[i]   <= a_retv;
					ret_q[i]    <= more_rep ? cursor_q[i] : ret_q[i];
					count_q[i]  <= a_count;
					trail_q[i]  <= a_trail;
					wait_q[i]   <= wait_q[i] + $signed(a_delay) - WAIT_ONE;
					if (a_finish) begin
						ena_q[i] <= 1'b0;
					end
				end
				// successor starts now, without awaiting the last delay
				if (chain_go && succ_q[f] == 5'(i)) begin
					ena_q[i]    <= 1'b1;
					cursor_q[i] <= head_q[i];
					rep_q[i]    <= 8'h00;
					retv_q[i]   <= 1'b0;
					trail_q[i]  <= 8'h00;
					wait_q[i]   <= '0;
				end
				if (bus_flow == 5'(i)) begin
					if (wr_mode) begin
						mode_q[i]    <= avs_writedata_i[frame_injector_pkg::MODE_BIT];
						trail_n_q[i] <= avs_writedata_i[frame_injector_pkg::TRAIL_LSB +: 8];
					end
					if (wr_ptrs) begin
						head_q[i]   <= avs_writedata_i[frame_injector_pkg::HEAD_LSB +: PW];
						cursor_q[i] <= avs_writedata_i[frame_injector_pkg::CURSOR_LSB +: PW];
					end
					if (wr_count) begin
						count_q[i] <= avs_writedata_i[15:0];
					end
					if (wr_dest) begin
						dest_q[i] <= be_merge(dest_q[i], avs_writedata_i, avs_byteenable_i)
							& DEST_MASK;
					end
					if (wr_ctrl) begin
						ena_q[i]   <= avs_writedata_i[frame_injector_pkg::ENA_BIT];
						rate_q[i]  <= avs_writedata_i[frame_injector_pkg::RATE_BIT];
						succ_q[i]  <= avs_writedata_i[frame_injector_pkg::SUCC_LSB +: 5];
						chain_q[i] <= avs_writedata_i[frame_injector_pkg::CHAIN_BIT];
						// a fresh enable restarts the walk at the head
						if (avs_writedata_i[frame_injector_pkg::ENA_BIT] && !ena_q[i]) begin
							cursor_q[i] <= head_q[i];
							rep_q[i]    <= 8'h00;
							retv_q[i]   <= 1'b0;
							trail_q[i]  <= 8'h00;
							wait_q[i]   <= '0;
						end
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// shared engine sequencer
	// ----------------------------------------------------------------
	wire [4:0]  pick      = rr_pick(eligible, eng_flow_q);
	wire [31:0] pick_dest = dest_q[pick];
	wire        to_ingress = pick_dest[frame_injector_pkg::INGRESS_BIT];

	// idle -> 12 processing cycles -> inject handshake; two frames back to
	// back therefore start 14 cycles apart, which bounds per-flow rate
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			eng_state_q <= frame_injector_pkg::ENG_IDLE;
			eng_flow_q  <= 5'h00;
			proc_cnt_q  <= 4'h0;
			entry_q     <= frame_injector_pkg::RST_WORD;
			entry_ptr_q <= '0;
		end else begin
			case (eng_state_q)
				frame_injector_pkg::ENG_IDLE: begin
					if (|eligible) begin
						eng_flow_q  <= pick;
						entry_q     <= ftab_mem[cursor_q[pick]];
						entry_ptr_q <= cursor_q[pick];
						proc_cnt_q  <= frame_injector_pkg::PROC_LAST;
						eng_state_q <= frame_injector_pkg::ENG_PROC;
					end
				end
				frame_injector_pkg::ENG_PROC: begin
					proc_cnt_q <= proc_cnt_q - 4'h1;
					if (proc_cnt_q == '0) begin
						eng_state_q <= ent_delay ? frame_injector_pkg::ENG_IDLE
							: frame_injector_pkg::ENG_INJECT;
					end
				end
				frame_injector_pkg::ENG_INJECT: begin
					if (inject_ready_i) begin
						eng_state_q <= frame_injector_pkg::ENG_IDLE;
					end
				end
				default: eng_state_q <= frame_injector_pkg::ENG_IDLE;
			endcase
		end
	end

	// injection request; its fields stand until the sink takes it, so a flow
	// disabled meanwhile still completes the injection in flight
	wire [31:0] f_dest    = dest_q[f];
	wire        f_ingress = f_dest[frame_injector_pkg::INGRESS_BIT];
	wire        inj_start = eng_state_q == frame_injector_pkg::ENG_PROC && proc_cnt_q == '0
		&& !ent_delay;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			inj_valid_q <= 1'b0;
			inj_frame_q <= 11'h000;
			inj_port_q  <= 7'h00;
			inj_qidx_q  <= 11'h000;
			inj_qinp_q  <= 3'h0;
			inj_rate_q  <= 1'b0;
			inj_loop_q  <= 1'b0;
			inj_flow_q  <= 5'h00;
		end else if (inj_start) begin
			inj_valid_q <= 1'b1;
			inj_frame_q <= entry_q[frame_injector_pkg::FRAME_W-1:0];
			inj_port_q  <= f_ingress ? LOOPBACK_PORT
				: f_dest[frame_injector_pkg::PORT_LSB +: 7];
			inj_qidx_q  <= f_dest[frame_injector_pkg::QIDX_LSB +: 11];
			inj_qinp_q  <= f_dest[frame_injector_pkg::QINP_LSB +: 3];
			inj_rate_q  <= rate_q[f];
			inj_loop_q  <= f_ingress;
			inj_flow_q  <= f;
		end else if (inj_valid_q && inject_ready_i) begin
			inj_valid_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign avs_readdata_o      = rdata_q;
	assign avs_waitrequest_o   = wait_req_q;
	assign inject_valid_o      = inj_valid_q;
	assign inject_frame_o      = inj_frame_q;
	assign inject_port_o       = inj_port_q;
	assign inject_qidx_o       = inj_qidx_q;
	assign inject_qinp_o       = inj_qinp_q;
	assign inject_rate_class_o = inj_rate_q;
	assign inject_loopback_o   = inj_loop_q;
	assign inject_flow_o       = inj_flow_q;

	// entry_ptr_q and to_ingress kept for readback-free debug visibility
	wire unused_dbg = ^{entry_ptr_q, to_ingress};

endmodule

/* File: frame_injector_pkg.sv */
// constants, register map and field layout shared by the delay-paced frame injector
// assumes a 100 MHz system clock and a 32-bit avalon-mm register bus

package frame_injector_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int unsigned FLOW_MAX      = 32;
	localparam int unsigned FLOW_W        = 5;
	localparam int unsigned PTR_W         = 12;
	localparam int unsigned FTAB_MAX      = 4096;
	localparam int unsigned WAIT_W        = 21;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned PROC_CYCLES   = 12;
	localparam logic [3:0]  PROC_LAST     = 4'(PROC_CYCLES - 1);
	localparam logic signed [WAIT_W-1:0] WAIT_FLOOR = -21'sd64;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [15:0] FTAB_BASE     = 16'h8000;
	localparam logic [4:0]  REG_MODE      = 5'h00;
	localparam logic [4:0]  REG_PTRS      = 5'h04;
	localparam logic [4:0]  REG_COUNT     = 5'h08;
	localparam logic [4:0]  REG_DEST      = 5'h0C;
	localparam logic [4:0]  REG_CTRL      = 5'h10;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned MODE_BIT      = 0;
	localparam int unsigned TRAIL_LSB     = 8;
	localparam int unsigned HEAD_LSB      = 0;
	localparam int unsigned CURSOR_LSB    = 16;
	localparam int unsigned PORT_LSB      = 0;
	localparam int unsigned QIDX_LSB      = 8;
	localparam int unsigned QINP_LSB      = 20;
	localparam int unsigned INGRESS_BIT   = 31;
	localparam int unsigned ENA_BIT       = 0;
	localparam int unsigned RATE_BIT      = 1;
	localparam int unsigned SUCC_LSB      = 8;
	localparam int unsigned CHAIN_BIT     = 13;
	localparam int unsigned REP_LSB       = 24;
	localparam int unsigned TYPE_BIT      = 31;
	localparam int unsigned NEXT_LSB      = 19;
	localparam int unsigned REPEAT_LSB    = 11;
	localparam int unsigned FRAME_W       = 11;
	localparam int unsigned DELAY_W       = 19;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_WORD      = 32'h0000_0000;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

	// ----------------------------------------------------------------
	// engine states, gray along idle -> process -> inject
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ENG_IDLE   = 2'b00,
		ENG_PROC   = 2'b01,
		ENG_INJECT = 2'b11
	} engine_state_type;

endpackage

/* File: delay_paced_frame_injector_props.sv */
// port checker for the delay-paced frame injector
// assumes it is bound to delay_paced_frame_injector
`timescale 1ns/1ps
module injector_props #(
	parameter logic [6:0] LOOPBACK_PORT = 7'h40
) (
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic [15:0] avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic        inject_ready_i,
	input wire logic        inject_valid_o,
	input wire logic [10:0] inject_frame_o,
	input wire logic [6:0]  inject_port_o,
	input wire logic        inject_loopback_o,
	input wire logic [4:0]  inject_flow_o
);
	// ----------------------------------------------------------------
	// bus and injection timing
	// ----------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_rel; $fell(sys_rst_i) |-> avs_waitrequest_o && !inject_valid_o; endproperty
	a_rel: assert property (p_rel) else $error("outputs busy at reset release");
	property p_ans; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
	a_ans: assert property (p_ans) else $error("bus answer late");
	property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
	a_one: assert property (p_one) else $error("answer longer than one cycle");
	// gap between the flow block and the frame table reads as zero
	property p_gap; avs_read_i && !avs_waitrequest_o && avs_address_i inside
		{[16'h0400:16'h7FFF]} |-> avs_readdata_o == 32'h0; endproperty
	a_gap: assert property (p_gap) else $error("unmapped read not zero");
	property p_take; inject_valid_o && inject_ready_i |=> !inject_valid_o; endproperty
	a_take: assert property (p_take) else $error("valid held after take");
	property p_hold; inject_valid_o && !inject_ready_i |=> inject_valid_o &&
		$stable(inject_frame_o) && $stable(inject_port_o) && $stable(inject_flow_o); endproperty
	a_hold: assert property (p_hold) else $error("injection dropped while stalled");
	property p_loop; inject_valid_o && inject_loopback_o |-> inject_port_o == LOOPBACK_PORT; endproperty
	a_loop: assert property (p_loop) else $error("ingress frame not on loopback port");
	// one engine: starts at least 14 cycles apart
	property p_space; $rose(inject_valid_o) |=> (!$rose(inject_valid_o))[*8] ##1
		(!$rose(inject_valid_o))[*5]; endproperty
	a_space: assert property (p_space) else $error("injections too close");
endmodule
bind delay_paced_frame_injector injector_props #(.LOOPBACK_PORT(LOOPBACK_PORT)) props_i (
	.clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
	.avs_waitrequest_o, .inject_ready_i, .inject_valid_o, .inject_frame_o, .inject_port_o,
	.inject_loopback_o, .inject_flow_o);

/* File: inject_sink_model.sv */
// queue system sink taking injected frames
// assumes the injector clock; slow_i adds pseudo-random stalls
`timescale 1ns/1ps
module inject_sink_model (
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	input  wire logic slow_i,
	output logic      ready_o
);
	logic [15:0] lfsr_q;
	// stalls model a queue draining slower than it is fed
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lfsr_q  <= 16'hACE1;
			ready_o <= 1'b0;
		end else begin
			lfsr_q  <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
			ready_o <= !slow_i || lfsr_q[0];
		end
	end
endmodule

/* File: delay_paced_frame_injector_tb_top.sv */
// self-checking bench for the delay-paced frame injector
// assumes the props bind and inject_sink_model are compiled alongside
`timescale 1ns/1ps
module delay_paced_frame_injector_tb_top;
	localparam logic [6:0] LB = 7'h40;
	logic        clk_i = 0, sys_rst_i = 1, avs_read_i = 0, avs_write_i = 0;
	logic        inject_ready_i, avs_waitrequest_o, inject_valid_o;
	logic        inject_rate_class_o, inject_loopback_o;
	logic [15:0] avs_address_i = '0;
	logic [31:0] avs_writedata_i = '0, avs_readdata_o, seed = 32'h3D0E;
	logic [10:0] inject_frame_o, inject_qidx_o;
	logic [6:0]  inject_port_o;
	logic [2:0]  inject_qinp_o;
	logic [4:0]  inject_flow_o;
	int          err_count = 0, num_checks = 0;
	logic [31:0] rd_q[$];
	logic [63:0] inj_q[$];
	time         tk[$];
	// frame table: 0 unused, 1 frame x2, 2 delay 40, 3 frame, 4 successor frame, 5 delay 500
	// every delay outlasts the wire time of the frame before it
	logic [31:0] tab [6] = '{32'h0, 32'h0010_1155, 32'h8018_0028, 32'h0028_0AAA,
		32'h0000_08AB, 32'h8000_01F4};
	// flow 2 first, flow 1 enable last: count mode, one pass, chained to flow 2
	logic [47:0] cfg [9] = '{{16'h0040, 32'h1}, {16'h0044, 32'h4}, {16'h0048, 32'h1},
		{16'h004C, 32'h5}, {16'h0020, 32'h1}, {16'h0024, 32'h1}, {16'h0028, 32'h1},
		{16'h002C, 32'h8051_2303}, {16'h0030, 32'h0000_2203}};

	always #5 clk_i = ~clk_i;

	delay_paced_frame_injector #(.LOOPBACK_PORT(LB)) dut (.clk_i, .sys_rst_i,
		.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .inject_ready_i,
		.inject_valid_o, .inject_frame_o, .inject_port_o, .inject_qidx_o, .inject_qinp_o,
		.inject_rate_class_o, .inject_loopback_o, .inject_flow_o);
	inject_sink_model sink (.clk_i, .sys_rst_i, .slow_i(1'b1), .ready_o(inject_ready_i));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one avalon cycle, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_i);
		avs_read_i <= !w;
		avs_write_i <= w;
		avs_address_i <= a;
		avs_writedata_i <= d;
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask

	task automatic rdx(input logic [15:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// watcher: each result seen takes the oldest note
	always @(posedge clk_i) begin
		if (avs_read_i && avs_waitrequest_o === 1'b0)
			check(avs_readdata_o, rd_q.pop_front(), "readdata");
		if (inject_valid_o === 1'b1 && inject_ready_i === 1'b1) begin
			tk.push_back($time);
			check({inject_flow_o, inject_port_o, inject_frame_o, inject_qidx_o, inject_qinp_o,
				inject_loopback_o, inject_rate_class_o}, inj_q.pop_front(), "injection");
		end
	end

	initial begin
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rdx(16'h0010, frame_injector_pkg::RST_WORD);
		bus(1'b1, 16'h0400, 32'hFFFF_FFFF);
		rdx(16'h0400, frame_injector_pkg::READ_UNMAPPED);
		seed = lfsr(seed);
		bus(1'b1, 16'h006C, seed);
		rdx(16'h006C, seed & 32'h807F_FF7F);
		$display("register test done");
		repeat (2) inj_q.push_back({5'd1, LB, 11'h155, 11'h123, 3'h5, 2'b11});
		inj_q.push_back({5'd1, LB, 11'h2AA, 11'h123, 3'h5, 2'b11});
		inj_q.push_back({5'd2, 7'h05, 11'h0AB, 11'h0, 3'h0, 2'b00});
		foreach (tab[i]) bus(1'b1, 16'h8000 + 16'(4 * i), tab[i]);
		foreach (cfg[i]) bus(1'b1, cfg[i][47:32], cfg[i][31:0]);
		while (inj_q.size() != 0) @(posedge clk_i);
		check(64'(tk[1] - tk[0] >= 400), 64'h1, "repeat gap");
		check(64'(tk[3] - tk[2] < 1000), 64'h1, "chain gap");
		$display("chain test done");
		results();
	end

	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		#200000;
		err_count++;
		$display("watchdog expired");
		results();
	end
endmodule
